// ### rtl/mii_phy_pkg.sv
// Constants, state codes and shared helpers for the MII port and LED logic.
// Assumes a 10 MHz system clock and a 25 MHz reference clock on the link side.
package mii_phy_pkg;
  localparam int SYS_CLOCK_HZ = 10_000_000;
  localparam int REF_CLOCK_HZ = 25_000_000;
  localparam int MII_TEN_MEG_HZ = 2_500_000;
  localparam int BLINK_SLOW_HZ = 10;
  localparam int BLINK_FAST_HZ = 20;
  localparam int ACT_HOLD_MS = 100;
  localparam int TEN_MEG_DIV_HALF = REF_CLOCK_HZ / (2 * MII_TEN_MEG_HZ);

  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_INT_STATUS = 5'h11;
  localparam logic [4:0] REG_INT_ENABLE = 5'h12;
  localparam logic [4:0] REG_STRAP_ADDR = 5'h14;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] INT_ENABLE_RESET = 16'h0000;
  localparam int DUPLEX_BIT = 8;
  localparam int STRAP_LSB = 3;

  localparam int INT_LINK = 0;
  localparam int INT_SPEED = 1;
  localparam int INT_DUPLEX = 2;
  localparam int INT_COLL = 3;
  localparam int INT_COUNT = 4;

  localparam logic [4:0] INVALID_CODE = 5'h04;

  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] HEADER_BITS = 5'h0d;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [2:0] STRAP_SETTLE = 3'h6;

  localparam int PIN_MDC = 0;
  localparam int PIN_MDIO = 1;
  localparam int PIN_COLL = 2;
  localparam int PIN_LINK = 3;
  localparam int PIN_SPEED = 4;
  localparam int PIN_STRAP = 5;
  localparam int PIN_COUNT = 10;
  localparam int LED_COUNT = 5;

  localparam int LED_HUNDRED = 0;
  localparam int LED_DUPLEX = 1;
  localparam int LED_LINK = 2;
  localparam int LED_ACT = 3;
  localparam int LED_TEN = 4;

  typedef enum logic [4:0] {
    MG_PREAMBLE = 5'b00001,
    MG_HEADER = 5'b00010,
    MG_TURN = 5'b00100,
    MG_READ = 5'b01000,
    MG_WRITE = 5'b10000
  } mgmt_state_e;

  // A pin change counts once the second and third stages agree
  function automatic logic [PIN_COUNT-1:0] sync_filter(
    input logic [PIN_COUNT-1:0] s2,
    input logic [PIN_COUNT-1:0] s3,
    input logic [PIN_COUNT-1:0] held
  );
    sync_filter = (s2 & s3) | (held & (s2 ^ s3));
  endfunction
endpackage

// ### rtl/mgmt_if.sv
// Register access and serial pin signals between the frame engine and the top.
// Assumes both ends run on the system clock.
interface mgmt_if;
  logic [4:0] reg_addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [4:0] phy_addr;
  logic mdc_rise;
  logic mdio_bit;
  logic mdio_out;
  logic mdio_oe;
  modport engine (
    input rdata, phy_addr, mdc_rise, mdio_bit,
    output reg_addr, wdata, wr, rd, mdio_out, mdio_oe
  );
  modport regs (
    output rdata, phy_addr, mdc_rise, mdio_bit,
    input reg_addr, wdata, wr, rd, mdio_out, mdio_oe
  );
endinterface

// ### rtl/mgmt_frame_engine.sv
// Serial management frame decoder: read and write frames to this address.
// Assumes the management clock edge and data bit arrive already synchronised.
module mgmt_frame_engine
  import mii_phy_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  mgmt_if.engine mif
);
  typedef struct packed {
    mgmt_state_e state;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic is_read;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic out;
    logic oe;
  } eng_s;

  localparam eng_s ENG_RESET = '{state: MG_PREAMBLE, default: '0};

  eng_s st;
  eng_s next_st;
  logic [12:0] hdr;

  always_comb
  begin
    next_st = st;
    hdr = {st.shift[11:0], mif.mdio_bit};
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    if (mif.mdc_rise)
    begin
      unique case (st.state)
        MG_PREAMBLE:
        begin
          if (mif.mdio_bit)
          begin
            if (st.ones != PREAMBLE_ONES)
              next_st.ones = st.ones + 6'h01;
          end
          else if (st.ones == PREAMBLE_ONES)
          begin
            next_st.state = MG_HEADER;
            next_st.cnt = '0;
            next_st.ones = '0;
          end
          else
            next_st.ones = '0;
        end
        MG_HEADER:
        begin
          next_st.shift = {st.shift[14:0], mif.mdio_bit};
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == HEADER_BITS - 5'h01)
          begin
            next_st.cnt = '0;
            next_st.state = MG_PREAMBLE;
            if (hdr[12] && hdr[9:5] == mif.phy_addr &&
                (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE))
            begin
              next_st.state = MG_TURN;
              next_st.is_read = (hdr[11:10] == OP_READ);
              next_st.reg_addr = hdr[4:0];
              next_st.rd = (hdr[11:10] == OP_READ);
            end
          end
        end
        MG_TURN:
        begin
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == 5'h00)
          begin
            // Second turnaround bit is ours to drive low on a read
            next_st.oe = st.is_read;
            next_st.out = 1'b0;
          end
          else if (st.is_read)
          begin
            next_st.out = mif.rdata[15];
            next_st.shift = {mif.rdata[14:0], 1'b0};
            next_st.state = MG_READ;
          end
          else
          begin
            next_st.cnt = '0;
            next_st.state = MG_WRITE;
          end
        end
        MG_READ:
        begin
          if (st.cnt == DATA_BITS + 5'h01)
          begin
            next_st.oe = 1'b0;
            next_st.out = 1'b0;
            next_st.cnt = '0;
            next_st.state = MG_PREAMBLE;
          end
          else
          begin
            next_st.out = st.shift[15];
            next_st.shift = {st.shift[14:0], 1'b0};
            next_st.cnt = st.cnt + 5'h01;
          end
        end
        MG_WRITE:
        begin
          next_st.wdata = {st.wdata[14:0], mif.mdio_bit};
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == DATA_BITS - 5'h01)
          begin
            next_st.wr = 1'b1;
            next_st.cnt = '0;
            next_st.state = MG_PREAMBLE;
          end
        end
        default:
          next_st = ENG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st <= ENG_RESET;
    else
      st <= next_st;
  end

  assign mif.reg_addr = st.reg_addr;
  assign mif.wdata = st.wdata;
  assign mif.wr = st.wr;
  assign mif.rd = st.rd;
  assign mif.mdio_out = st.out;
  assign mif.mdio_oe = st.oe;

  read_turn_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st.state == MG_TURN && st.is_read && st.cnt == 5'h00 && mif.mdc_rise)
    |=> (mif.mdio_oe && !mif.mdio_out))
    else $error("read turnaround not driven low");

  write_after_data_a: assert property (@(posedge clk_sys) disable iff (rst)
    mif.wr |-> ($past(st.state) == MG_WRITE && st.state == MG_PREAMBLE))
    else $error("write strobe outside data phase");
endmodule

// ### rtl/mii_phy_port_and_led_hundred_meg_link.sv
// MII data and control port of a 10/100 transceiver with LED display and straps.
// Assumes line-side coder logic runs on the reference clock; pins are asynchronous.
module mii_phy_port_and_led_hundred_meg_link
  import mii_phy_pkg::*;
#(
  parameter int BLINK_SLOW_HALF = REF_CLOCK_HZ / (2 * BLINK_SLOW_HZ),
  parameter int BLINK_FAST_HALF = REF_CLOCK_HZ / (2 * BLINK_FAST_HZ),
  parameter int ACT_HOLD_CYCLES = SYS_CLOCK_HZ / 1000 * ACT_HOLD_MS
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ref_clock_in,
  output logic ref_clock_out,
  output logic mii_tx_clk,
  input wire logic [4:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  output logic mii_rx_clk,
  output logic [4:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic mii_col,
  output logic mii_crs,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic mgmt_interrupt_n_out,
  output logic mgmt_interrupt_n_oe,
  input wire logic [4:0] led_in,
  output logic [4:0] led_out,
  output logic [4:0] led_oe,
  output logic [4:0] line_tx_code,
  output logic line_tx_en,
  input wire logic [4:0] line_rx_code,
  input wire logic line_rx_valid,
  input wire logic line_rx_invalid,
  input wire logic line_rx_nonidle,
  input wire logic line_collision,
  input wire logic line_link_good,
  input wire logic line_speed_100,
  input wire logic symbol_mode,
  input wire logic led_mode_four
);
  localparam int BW = $clog2(BLINK_SLOW_HALF + 1);
  localparam int HW = $clog2(ACT_HOLD_CYCLES + 1);
  localparam logic [2:0] DIV_LAST = 3'(TEN_MEG_DIV_HALF - 1);
  localparam logic [BW-1:0] SLOW_LAST = BW'(BLINK_SLOW_HALF - 1);
  localparam logic [BW-1:0] FAST_LAST = BW'(BLINK_FAST_HALF - 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(ACT_HOLD_CYCLES - 1);

  // Link domain, clocked by the reference clock
  typedef struct packed {
    logic r1;
    logic r2;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [2:0] div;
    logic div_clk;
    logic [BW-1:0] slow_cnt;
    logic slow;
    logic [BW-1:0] fast_cnt;
    logic fast;
    logic [4:0] tx_code;
    logic tx_en;
    logic [4:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic act;
  } link_s;

  // System domain
  typedef struct packed {
    logic [PIN_COUNT-1:0] pin1;
    logic [PIN_COUNT-1:0] pin2;
    logic [PIN_COUNT-1:0] pin3;
    logic [PIN_COUNT-1:0] pin;
    logic mdc_prev;
    logic [2:0] cross1;
    logic [2:0] cross2;
    logic [15:0] control;
    logic [15:0] int_status;
    logic [15:0] int_enable;
    logic [15:0] rdata;
    logic [2:0] strap_cnt;
    logic strap_done;
    logic [4:0] strap;
    logic [INT_COUNT-1:0] prev;
    logic [HW-1:0] act_hold;
    logic [HW-1:0] col_hold;
    logic [4:0] led;
    logic int_oe;
  } sys_s;

  localparam link_s LINK_RESET = '0;
  localparam sys_s SYS_RESET = '{control: CONTROL_RESET, int_enable: INT_ENABLE_RESET,
    default: '0};

  function automatic logic [BW-1:0] wrap_step(
    input logic [BW-1:0] c,
    input logic [BW-1:0] last
  );
    wrap_step = (c == last) ? '0 : c + 1'b1;
  endfunction

  function automatic logic [HW-1:0] hold_step(
    input logic trig,
    input logic [HW-1:0] c
  );
    hold_step = trig ? HOLD_LAST : ((c != '0) ? c - 1'b1 : c);
  endfunction

  link_s lk;
  link_s next_lk;
  sys_s st;
  sys_s next_st;
  logic link_rst;
  logic speed_link;
  logic sym_link;
  logic tick;
  logic full_duplex;
  logic [INT_COUNT-1:0] cur;
  logic [INT_COUNT-1:0] ev;
  logic rd_status;
  logic act_on;
  logic col_on;
  logic [4:0] led_on;

  mgmt_if mif ();

  mgmt_frame_engine u_engine (
    .clk_sys(clk_sys),
    .rst(rst),
    .mif(mif)
  );

  assign link_rst = lk.r2;
  assign speed_link = lk.s2[1];
  assign sym_link = lk.s2[0];
  assign tick = speed_link || (lk.div == DIV_LAST && !lk.div_clk);

  always_comb
  begin
    next_lk = lk;
    next_lk.r1 = rst;
    next_lk.r2 = lk.r1;
    next_lk.s1 = {st.pin[PIN_SPEED], symbol_mode};
    next_lk.s2 = lk.s1;
    if (speed_link)
    begin
      next_lk.div = '0;
      next_lk.div_clk = 1'b0;
    end
    else if (lk.div == DIV_LAST)
    begin
      next_lk.div = '0;
      next_lk.div_clk = !lk.div_clk;
    end
    else
      next_lk.div = lk.div + 3'h1;
    next_lk.slow_cnt = wrap_step(lk.slow_cnt, SLOW_LAST);
    next_lk.fast_cnt = wrap_step(lk.fast_cnt, FAST_LAST);
    if (lk.slow_cnt == SLOW_LAST)
      next_lk.slow = !lk.slow;
    if (lk.fast_cnt == FAST_LAST)
      next_lk.fast = !lk.fast;
    if (tick)
    begin
      // data taken on the transmit clock edge
      next_lk.tx_en = mii_tx_en;
      if (sym_link)
        next_lk.tx_code = {mii_txd[4] | mii_tx_er, mii_txd[3:0]};
      else if (speed_link && mii_tx_er)
        next_lk.tx_code = INVALID_CODE;
      else
        next_lk.tx_code = {1'b0, mii_txd[3:0]};
      next_lk.rxd = {sym_link & line_rx_code[4], line_rx_code[3:0]};
      next_lk.rx_dv = line_rx_valid;
      next_lk.rx_er = sym_link ? line_rx_code[4] : line_rx_invalid;
    end
    next_lk.act = lk.tx_en | lk.rx_dv;
  end

  always_ff @(posedge ref_clock_in)
  begin
    if (link_rst)
    begin
      lk <= LINK_RESET;
      lk.r1 <= next_lk.r1;
      lk.r2 <= next_lk.r2;
    end
    else
      lk <= next_lk;
  end

  assign full_duplex = st.control[DUPLEX_BIT];
  assign cur = {st.pin[PIN_COLL], full_duplex, st.pin[PIN_SPEED], st.pin[PIN_LINK]};
  // Pins still filling after reset would look like link and speed changes
  assign ev = {INT_COUNT{st.strap_done}} &
    {cur[INT_COLL] & !st.prev[INT_COLL], cur[INT_COLL-1:0] ^ st.prev[INT_COLL-1:0]};
  assign rd_status = mif.rd && mif.reg_addr == REG_INT_STATUS;
  assign act_on = st.act_hold != '0;
  assign col_on = st.col_hold != '0;

  always_comb
  begin
    next_st = st;
    next_st.pin1 = {led_in, line_speed_100, line_link_good, line_collision, mdio_in, mdc};
    next_st.pin2 = st.pin1;
    next_st.pin3 = st.pin2;
    next_st.pin = sync_filter(st.pin2, st.pin3, st.pin);
    next_st.mdc_prev = st.pin[PIN_MDC];
    next_st.cross1 = {lk.act, lk.slow, lk.fast};
    next_st.cross2 = st.cross1;
    // strap capture after reset release, LED drivers still off
    if (!st.strap_done)
    begin
      next_st.strap_cnt = st.strap_cnt + 3'h1;
      if (st.strap_cnt == STRAP_SETTLE)
      begin
        next_st.strap = st.pin[PIN_STRAP +: LED_COUNT];
        next_st.strap_done = 1'b1;
      end
    end
    if (mif.wr)
    begin
      if (mif.reg_addr == REG_CONTROL)
        next_st.control = mif.wdata;
      else if (mif.reg_addr == REG_INT_ENABLE)
        next_st.int_enable = mif.wdata;
    end
    if (mif.rd)
    begin
      unique case (mif.reg_addr)
        REG_CONTROL: next_st.rdata = st.control;
        REG_INT_STATUS: next_st.rdata = st.int_status;
        REG_INT_ENABLE: next_st.rdata = st.int_enable;
        REG_STRAP_ADDR: next_st.rdata = 16'(st.strap) << STRAP_LSB;
        default: next_st.rdata = '0;
      endcase
    end
    next_st.prev = cur;
    // read clears; a new event in the same cycle still sets
    next_st.int_status = (rd_status ? '0 : st.int_status) | 16'(ev);
    next_st.int_oe = |(next_st.int_status & next_st.int_enable);
    next_st.act_hold = hold_step(st.cross2[2], st.act_hold);
    next_st.col_hold = hold_step(st.pin[PIN_COLL] & !full_duplex, st.col_hold);
    led_on = '0;
    led_on[LED_DUPLEX] = full_duplex | (col_on & st.cross2[0]);
    if (led_mode_four)
    begin
      led_on[LED_HUNDRED] = st.pin[PIN_LINK] & st.pin[PIN_SPEED];
      led_on[LED_TEN] = st.pin[PIN_LINK] & !st.pin[PIN_SPEED];
      led_on[LED_ACT] = act_on & st.cross2[1];
    end
    else
    begin
      led_on[LED_HUNDRED] = st.pin[PIN_SPEED];
      led_on[LED_LINK] = st.pin[PIN_LINK] & ((act_on & !col_on) ? st.cross2[1] : 1'b1);
    end
    // strap high gives an active-low driver
    next_st.led = led_on ^ next_st.strap;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st <= SYS_RESET;
    else
      st <= next_st;
  end

  assign mif.rdata = st.rdata;
  assign mif.phy_addr = st.strap;
  // No frame before the address is captured; this also hides the false edge
  // that the pin filter shows while it fills after reset
  assign mif.mdc_rise = st.pin[PIN_MDC] & !st.mdc_prev & st.strap_done;
  assign mif.mdio_bit = st.pin[PIN_MDIO];
  assign mdio_out = mif.mdio_out;
  assign mdio_oe = mif.mdio_oe;

  // clock outputs; 100 Mbps passes the reference through
  assign mii_tx_clk = speed_link ? ref_clock_in : lk.div_clk;
  assign mii_rx_clk = speed_link ? ref_clock_in : lk.div_clk;
  assign ref_clock_out = !ref_clock_in;
  assign line_tx_code = lk.tx_code;
  assign line_tx_en = lk.tx_en;
  assign mii_rxd = lk.rxd;
  assign mii_rx_dv = lk.rx_dv;
  assign mii_rx_er = lk.rx_er;
  assign mii_col = line_collision & !full_duplex;
  assign mii_crs = line_rx_nonidle | (lk.tx_en & !full_duplex);
  assign mgmt_interrupt_n_out = 1'b0;
  assign mgmt_interrupt_n_oe = st.int_oe;
  assign led_out = st.led;
  assign led_oe = {LED_COUNT{st.strap_done}};

  tx_invalid_code_a: assert property (@(posedge ref_clock_in) disable iff (link_rst)
    (tick && speed_link && !sym_link && mii_tx_er) |=> (line_tx_code == INVALID_CODE))
    else $error("tx error did not send invalid code");

  tx_symbol_bit_a: assert property (@(posedge ref_clock_in) disable iff (link_rst)
    (tick && sym_link) |=> (line_tx_code[4] == ($past(mii_txd[4]) | $past(mii_tx_er))))
    else $error("symbol mode fifth bit wrong");

  rx_valid_follow_a: assert property (@(posedge ref_clock_in) disable iff (link_rst)
    tick |=> (mii_rx_dv == $past(line_rx_valid)))
    else $error("rx valid does not follow received data");

  rx_fifth_bit_a: assert property (@(posedge ref_clock_in) disable iff (link_rst)
    (!sym_link && tick) |=> (mii_rxd[4] == 1'b0 && mii_rx_er == $past(line_rx_invalid)))
    else $error("fifth rx bit driven outside symbol mode");

  col_full_duplex_a: assert property (@(posedge clk_sys) disable iff (rst)
    full_duplex |-> !mii_col)
    else $error("collision shown in full duplex");

  crs_full_duplex_a: assert property (@(posedge clk_sys) disable iff (rst)
    (full_duplex && !line_rx_nonidle) |-> !mii_crs)
    else $error("carrier sense from transmit in full duplex");

  int_raise_a: assert property (@(posedge clk_sys) disable iff (rst)
    (|(16'(ev) & st.int_enable) && !mif.wr) |=> mgmt_interrupt_n_oe)
    else $error("enabled event did not pull interrupt low");

  int_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_status && ev == '0 && !mif.wr) |=> !mgmt_interrupt_n_oe)
    else $error("status read did not release interrupt");

  strap_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st.strap_done && $past(st.strap_done)) |-> $stable(st.strap))
    else $error("strap address changed after capture");

  led_drive_late_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(led_oe[0]) |-> (st.strap == $past(st.pin[PIN_STRAP +: LED_COUNT])))
    else $error("led drivers enabled before strap capture");
endmodule

// ### test/mac_model.sv
// MAC stand-in on the transmit side of the MII.
// Assumes the bench sets the wanted enable, error and data in want.
module mac_model
(
  input wire logic tx_clk,
  input wire logic [6:0] want,
  output logic [4:0] txd,
  output logic tx_en,
  output logic tx_er
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {tx_en, tx_er, txd} = 7'h00;
  // launch on clock
  // Idle data is scrambled so that a design that uses it shows up
  always @(posedge tx_clk)
  begin
    {tx_en, tx_er} <= want[6:5];
    txd <= want[6] ? want[4:0] : ~txd;
  end
endmodule

// ### test/testbench.sv
// Bench for the MII port and LED block: reset and strap check, table of data path cases, then hand tests.
// Assumes the MAC model on the transmit side and a pulled-up management data line.
module testbench
  import mii_phy_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] ctl;
    logic [4:0] txd;
    logic [4:0] rxc;
    logic [2:0] rin;
    logic [4:0] code;
    logic [4:0] rxd;
    logic [2:0] ost;
  } row_s;
  // ctl: speed, symbol, enable, error; rin: valid, invalid, nonidle; ost: dv, er, crs
  row_s rows [7] = '{
    '{4'ha, 5'h15, 5'h1a, 3'h4, 5'h05, 5'h0a, 3'h5},
    '{4'hb, 5'h03, 5'h03, 3'h7, 5'h04, 5'h03, 3'h7},
    '{4'he, 5'h15, 5'h1a, 3'h4, 5'h15, 5'h1a, 3'h7},
    '{4'hf, 5'h05, 5'h0a, 3'h4, 5'h15, 5'h0a, 3'h5},
    '{4'h8, 5'h0f, 5'h00, 3'h1, 5'h00, 5'h00, 3'h1},
    '{4'h3, 5'h06, 5'h09, 3'h4, 5'h06, 5'h09, 3'h5},
    '{4'h0, 5'h00, 5'h00, 3'h0, 5'h00, 5'h00, 3'h0}};
  localparam logic [4:0] STRAP = 5'h16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ref_clock_in, ref_clock_out, mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_rx_er;
  logic mii_col, mii_crs, mii_tx_en, mii_tx_er, mdc, mdio_in, mdio_out, mdio_oe;
  logic mgmt_interrupt_n_out, mgmt_interrupt_n_oe, line_rx_valid, line_rx_invalid;
  logic line_rx_nonidle, line_collision, line_link_good, line_speed_100, line_tx_en;
  logic symbol_mode, led_mode_four, m_drv, m_val, last;
  logic [4:0] mii_txd, mii_rxd, led_in, led_out, led_oe, line_tx_code, line_rx_code;
  logic [6:0] want;
  logic [7:0] n_tx, n_rx, cnt;
  logic [15:0] rd;
  int n_mismatch, comparisons;

  always #50 clk_sys = ~clk_sys;
  initial
  begin
    ref_clock_in = 1'b0;
    #37;
    forever #80 ref_clock_in = ~ref_clock_in;
  end
  // The strap resistor and the line pull-up win while nobody drives
  assign led_in = (led_oe & led_out) | (~led_oe & STRAP);
  assign mdio_in = mdio_oe ? mdio_out : (m_drv ? m_val : 1'b1);
  always @(posedge mii_tx_clk) n_tx <= n_tx + 8'h01;
  always @(posedge mii_rx_clk) n_rx <= n_rx + 8'h01;

  mac_model mac (.tx_clk(mii_tx_clk), .want(want), .txd(mii_txd), .tx_en(mii_tx_en),
    .tx_er(mii_tx_er));
  mii_phy_port_and_led_hundred_meg_link #(.BLINK_SLOW_HALF(4), .BLINK_FAST_HALF(2), .ACT_HOLD_CYCLES(20)) uut (
    .clk_sys(clk_sys), .rst(rst), .ref_clock_in(ref_clock_in), .ref_clock_out(ref_clock_out),
    .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er),
    .mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er),
    .mii_col(mii_col), .mii_crs(mii_crs), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mgmt_interrupt_n_out(mgmt_interrupt_n_out),
    .mgmt_interrupt_n_oe(mgmt_interrupt_n_oe), .led_in(led_in), .led_out(led_out),
    .led_oe(led_oe), .line_tx_code(line_tx_code), .line_tx_en(line_tx_en),
    .line_rx_code(line_rx_code), .line_rx_valid(line_rx_valid),
    .line_rx_invalid(line_rx_invalid), .line_rx_nonidle(line_rx_nonidle),
    .line_collision(line_collision), .line_link_good(line_link_good),
    .line_speed_100(line_speed_100), .symbol_mode(symbol_mode),
    .led_mode_four(led_mode_four));

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task done(input string nm);
    $display("END %s", nm);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wsys(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // management clock 1.25 MHz
  // The line is sampled just before the rise
  task mbit(input logic b, output logic s);
    @(negedge clk_sys);
    mdc = 1'b0;
    m_val = b;
    wsys(4);
    s = mdio_in;
    mdc = 1'b1;
    wsys(3);
  endtask
  task mframe(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
    output logic [15:0] q);
    logic s;
    logic [45:0] hdr;
    hdr = {32'hffff_ffff, 2'h1, op, STRAP, ra};
    m_drv = 1'b1;
    for (int i = 45; i >= 0; i--)
      mbit(hdr[i], s);
    if (op == OP_READ)
      m_drv = 1'b0;
    mbit(1'b1, s);
    mbit(1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      mbit(wd[i], s);
      q[i] = s;
    end
    m_drv = 1'b0;
    mbit(1'b1, s);
  endtask
  task meas(input logic [7:0] e);
    @(negedge ref_clock_in);
    n_tx = 8'h00;
    n_rx = 8'h00;
    repeat (20) @(negedge ref_clock_in);
    chk("tx clock rises", e, n_tx);
    chk("rx clock rises", e, n_rx);
    chk("ref_clock_out", 16'h0001, ref_clock_out);
    wsys(1);
  endtask
  task blinks(input int b);
    cnt = 8'h00;
    last = led_out[b];
    for (int i = 0; i < 60; i++)
    begin
      wsys(1);
      cnt = cnt + {7'h00, led_out[b] !== last};
      last = led_out[b];
    end
  endtask

  initial
  begin
    {mdc, m_val, line_link_good, line_speed_100} = 4'hf;
    {m_drv, symbol_mode, led_mode_four, line_collision} = 4'h0;
    {line_rx_valid, line_rx_invalid, line_rx_nonidle} = 3'h0;
    line_rx_code = 5'h00;
    want = 7'h00;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clock_in);
    @(negedge clk_sys);
    rst = 1'b0;
    chk("led_oe in reset", 16'h0000, led_oe);
    chk("mdio_oe in reset", 16'h0000, mdio_oe);
    wsys(12);
    chk("led_oe", 16'h001f, led_oe);
    mframe(OP_READ, REG_STRAP_ADDR, 16'h0000, rd);
    chk("strap register", 16'h00b0, rd);
    done("reset and straps");
    foreach (rows[i])
    begin
      @(negedge clk_sys);
      {line_speed_100, symbol_mode} = rows[i].ctl[3:2];
      want = {rows[i].ctl[1:0], rows[i].txd};
      @(negedge ref_clock_in);
      {line_rx_valid, line_rx_invalid, line_rx_nonidle} = rows[i].rin;
      line_rx_code = rows[i].rxc;
      repeat (40) @(negedge ref_clock_in);
      chk("line_tx_en", rows[i].ctl[1], line_tx_en);
      if (rows[i].ctl[1])
        chk("line_tx_code", rows[i].code, line_tx_code);
      if (rows[i].ost[2])
        chk("mii_rxd", rows[i].rxd, mii_rxd);
      chk("mii_rx_dv", rows[i].ost[2], mii_rx_dv);
      chk("mii_rx_er", rows[i].ost[1], mii_rx_er);
      chk("mii_crs", rows[i].ost[0], mii_crs);
    end
    done("data path rows");
    meas(8'h02);
    line_speed_100 = 1'b1;
    wsys(40);
    meas(8'h14);
    done("mii clocks");
    chk("three led idle", 16'h0013, led_out);
    led_mode_four = 1'b1;
    wsys(6);
    chk("four led 100", 16'h0017, led_out);
    line_speed_100 = 1'b0;
    wsys(40);
    chk("four led 10", 16'h0006, led_out);
    {line_speed_100, led_mode_four} = 2'h2;
    want = 7'h45;
    blinks(LED_LINK);
    chk("link blink", 16'h0001, {15'h0000, cnt > 8'h02});
    done("led_hundred_meg_link");
    line_collision = 1'b1;
    wsys(10);
    chk("col half duplex", 16'h0001, mii_col);
    blinks(LED_DUPLEX);
    chk("collision blink", 16'h0001, {15'h0000, cnt > 8'h02});
    mframe(OP_WRITE, REG_CONTROL, 16'h0100, rd);
    wsys(4);
    chk("col full duplex", 16'h0000, mii_col);
    chk("crs full duplex tx", 16'h0000, mii_crs);
    line_collision = 1'b0;
    wsys(40);
    chk("duplex led", 16'h0000, led_out[1]);
    want = 7'h00;
    done("collision and duplex");
    mframe(OP_READ, REG_INT_STATUS, 16'h0000, rd);
    mframe(OP_WRITE, REG_INT_ENABLE, 16'h0001, rd);
    chk("int idle", 16'h0000, mgmt_interrupt_n_oe);
    line_link_good = 1'b0;
    wsys(10);
    chk("int pulled low", 16'h0001, mgmt_interrupt_n_oe);
    chk("int level", 16'h0000, mgmt_interrupt_n_out);
    mframe(OP_READ, REG_INT_STATUS, 16'h0000, rd);
    chk("link status bit", 16'h0001, rd & 16'h0001);
    chk("int released", 16'h0000, mgmt_interrupt_n_oe);
    done("interrupt");
    close_out();
  end
endmodule
